// *** hw/rta_regs.vh ***
`ifndef RTA_REGS_VH
`define RTA_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RTA_CONTROL_OFF   6'h00
`define RTA_CORE_CLOCK_SELECT_FIELD_OFF    6'h04
`define RTA_IRQ_EN_OFF    6'h08
`define RTA_RAW_STAT_OFF  6'h0c
`define RTA_IRQ_CLR_OFF   6'h10
`define RTA_TICK_RLD_OFF  6'h14
`define RTA_TICK_CNT_OFF  6'h18
`define RTA_ALARM_RLD_OFF 6'h1c
`define RTA_TIME_CNT_OFF  6'h20

// ----------------------------------------
// field positions
// ----------------------------------------
`define RTA_RUN_BIT       0
`define RTA_TICK_BIT      0
`define RTA_MATCH_BIT     1
`define RTA_WRAP_BIT      2
`define RTA_CORE_CLOCK_SELECT_FIELD_MSB    1
`define RTA_TICK_RLD_MSB  19

// ----------------------------------------
// reset values
// ----------------------------------------
`define RTA_TICK_RLD_RST  20'h08000
`define RTA_ALARM_RLD_RST 32'hffffffff
`define RTA_ALL_ONES      32'hffffffff

// ----------------------------------------
// core clock select codes
// ----------------------------------------
`define RTA_SEL_INTERNAL_LOW_SPEED_OSC      2'h0
`define RTA_SEL_ELS       2'h1
`define RTA_SEL_EHS       2'h3

// ----------------------------------------
// fixed high-speed divider
// ----------------------------------------
`define RTA_EHS_DIV_W     7
`define RTA_EHS_DIV_LAST  7'h7f

`endif

// *** hw/rta_tick_alarm.v ***
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rta_regs.vh"

module rta_tick_alarm #(
  parameter SYNC_W = 3
) (
  // clock and resets
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        deep_sleep_wake_reset,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // core clock sources
  input  wire        internal_low_speed_osc,
  input  wire        external_low_speed_crystal,
  input  wire        external_high_speed_crystal,
  // interrupt lines
  output reg         tick_irq,
  output reg         match_irq,
  output reg         wrap_irq
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function hit;
    input [5:0] addr;
    input [5:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // ----------------------------------------
  // bus address phase capture
  // ----------------------------------------
  wire       addr_ok;
  reg        wr_pend_reg;
  reg  [5:0] wr_addr_reg;

  assign addr_ok = hsel & htrans[1] & hready;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 6'h00;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= addr_ok & hwrite & (haddr[31:6] == 26'h0000000);
      wr_addr_reg <= haddr[5:0];
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  // ----------------------------------------
  // write strobes in data phase
  // ----------------------------------------
  wire we_ctrl;
  wire we_sel;
  wire we_ie;
  wire we_clr;
  wire we_trld;
  wire we_arld;

  assign we_ctrl = wr_pend_reg & hit(wr_addr_reg, `RTA_CONTROL_OFF);
  assign we_sel  = wr_pend_reg & hit(wr_addr_reg, `RTA_CORE_CLOCK_SELECT_FIELD_OFF);
  assign we_ie   = wr_pend_reg & hit(wr_addr_reg, `RTA_IRQ_EN_OFF);
  assign we_clr  = wr_pend_reg & hit(wr_addr_reg, `RTA_IRQ_CLR_OFF);
  assign we_trld = wr_pend_reg & hit(wr_addr_reg, `RTA_TICK_RLD_OFF);
  assign we_arld = wr_pend_reg & hit(wr_addr_reg, `RTA_ALARM_RLD_OFF);

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  reg        run_reg;
  reg  [1:0] sel_reg;
  reg  [2:0] ie_reg;
  wire       run_rise;
  wire       sel_change;

  assign run_rise   = we_ctrl & hwdata[`RTA_RUN_BIT] & ~run_reg;
  assign sel_change = we_sel & (hwdata[`RTA_CORE_CLOCK_SELECT_FIELD_MSB:0] != sel_reg);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= 1'b0;
      sel_reg <= `RTA_SEL_INTERNAL_LOW_SPEED_OSC;
      ie_reg  <= 3'h0;
    end else begin
      if (we_ctrl) begin
        run_reg <= hwdata[`RTA_RUN_BIT];
      end
      if (we_sel) begin
        sel_reg <= hwdata[`RTA_CORE_CLOCK_SELECT_FIELD_MSB:0];
      end
      if (we_ie) begin
        ie_reg <= hwdata[`RTA_WRAP_BIT:`RTA_TICK_BIT];
      end
    end
  end

  // ----------------------------------------
  // core clock sampling
  // ----------------------------------------
  wire [SYNC_W-1:0] src_in;
  reg  [SYNC_W-1:0] src_s1_reg;
  reg  [SYNC_W-1:0] src_s2_reg;
  reg  [SYNC_W-1:0] src_s3_reg;
  wire [SYNC_W-1:0] src_rise;

  assign src_in = {external_high_speed_crystal,
                   external_low_speed_crystal,
                   internal_low_speed_osc};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          src_s1_reg[gi] <= 1'b0;
          src_s2_reg[gi] <= 1'b0;
          src_s3_reg[gi] <= 1'b0;
        end else begin
          src_s1_reg[gi] <= src_in[gi];
          src_s2_reg[gi] <= src_s1_reg[gi];
          src_s3_reg[gi] <= src_s2_reg[gi];
        end
      end
      assign src_rise[gi] = src_s2_reg[gi] & ~src_s3_reg[gi];
    end
  endgenerate

  // ----------------------------------------
  // high-speed divide by 128
  // ----------------------------------------
  reg  [`RTA_EHS_DIV_W-1:0] ehs_div_reg;
  wire                      ehs_ce;

  assign ehs_ce = src_rise[2] & (ehs_div_reg == `RTA_EHS_DIV_LAST);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ehs_div_reg <= {`RTA_EHS_DIV_W{1'b0}};
    end else if (src_rise[2]) begin
      ehs_div_reg <= ehs_div_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // core clock select
  // ----------------------------------------
  reg core_ce;

  always @* begin
    case (sel_reg)
      `RTA_SEL_INTERNAL_LOW_SPEED_OSC: core_ce = src_rise[0];
      `RTA_SEL_ELS:  core_ce = src_rise[1];
      `RTA_SEL_EHS:  core_ce = ehs_ce;
      default:       core_ce = 1'b0;
    endcase
  end

  // ----------------------------------------
  // reload registers
  // ----------------------------------------
  reg  [19:0] tick_reload_value_reg;
  reg  [31:0] alarm_reload_value_reg;
  wire [19:0] wr_tick_rld;

  assign wr_tick_rld = hwdata[`RTA_TICK_RLD_MSB:0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_reload_value_reg  <= `RTA_TICK_RLD_RST;
      alarm_reload_value_reg <= `RTA_ALARM_RLD_RST;
    end else if (deep_sleep_wake_reset) begin
      tick_reload_value_reg  <= `RTA_TICK_RLD_RST;
      alarm_reload_value_reg <= `RTA_ALARM_RLD_RST;
    end else begin
      if (we_trld) begin
        if (wr_tick_rld == 20'h00000) begin
          tick_reload_value_reg <= `RTA_TICK_RLD_RST;
        end else begin
          tick_reload_value_reg <= wr_tick_rld;
        end
      end
      if (we_arld) begin
        if (hwdata == 32'h00000000) begin
          alarm_reload_value_reg <= `RTA_ALARM_RLD_RST;
        end else begin
          alarm_reload_value_reg <= hwdata;
        end
      end
    end
  end

  // ----------------------------------------
  // counter clear causes
  // ----------------------------------------
  wire div_clr;
  wire time_clr;

  assign div_clr  = deep_sleep_wake_reset | run_rise | sel_change | we_trld;
  assign time_clr = div_clr | we_arld;

  // ----------------------------------------
  // tick divider and time counter
  // ----------------------------------------
  reg  [19:0] tick_divider_count_reg;
  reg  [31:0] time_counter_reg;
  reg         tick_pulse_reg;
  wire        step;
  wire        tick_match;
  wire [31:0] time_plus;

  assign step       = run_reg & core_ce;
  assign tick_match = step & (tick_divider_count_reg == tick_reload_value_reg);
  assign time_plus  = time_counter_reg + 32'h00000001;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_divider_count_reg <= 20'h00000;
    end else if (div_clr) begin
      tick_divider_count_reg <= 20'h00000;
    end else if (tick_match) begin
      tick_divider_count_reg <= 20'h00000;
    end else if (step) begin
      tick_divider_count_reg <= tick_divider_count_reg + 20'h00001;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_pulse_reg   <= 1'b0;
      time_counter_reg <= 32'h00000000;
    end else if (time_clr) begin
      tick_pulse_reg   <= 1'b0;
      time_counter_reg <= 32'h00000000;
    end else if (step) begin
      tick_pulse_reg <= tick_match;
      if (tick_pulse_reg) begin
        time_counter_reg <= time_plus;
      end
    end
  end

  // ----------------------------------------
  // flag set and clear
  // ----------------------------------------
  wire [2:0] flag_set;
  wire [2:0] flag_clr;
  reg  [2:0] flag_reg;
  wire [2:0] flag_next;

  assign flag_set[`RTA_TICK_BIT]  = tick_match;
  assign flag_set[`RTA_MATCH_BIT] = tick_match & (time_plus == alarm_reload_value_reg);
  assign flag_set[`RTA_WRAP_BIT]  = tick_match & (time_counter_reg == `RTA_ALL_ONES);
  assign flag_clr  = {3{we_clr}} & hwdata[`RTA_WRAP_BIT:`RTA_TICK_BIT];
  assign flag_next = (flag_reg & ~flag_clr) | flag_set;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg  <= 3'h0;
      tick_irq  <= 1'b0;
      match_irq <= 1'b0;
      wrap_irq  <= 1'b0;
    end else begin
      flag_reg  <= flag_next;
      tick_irq  <= flag_next[`RTA_TICK_BIT] & ie_reg[`RTA_TICK_BIT];
      match_irq <= flag_next[`RTA_MATCH_BIT] & ie_reg[`RTA_MATCH_BIT];
      wrap_irq  <= flag_next[`RTA_WRAP_BIT] & ie_reg[`RTA_WRAP_BIT];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  reg [31:0] rdata;

  always @* begin
    rdata = 32'h00000000;
    if (haddr[31:6] == 26'h0000000) begin
      case (haddr[5:0])
        `RTA_CONTROL_OFF:   rdata[`RTA_RUN_BIT] = run_reg;
        `RTA_CORE_CLOCK_SELECT_FIELD_OFF:    rdata[`RTA_CORE_CLOCK_SELECT_FIELD_MSB:0] = sel_reg;
        `RTA_IRQ_EN_OFF:    rdata[`RTA_WRAP_BIT:`RTA_TICK_BIT] = ie_reg;
        `RTA_RAW_STAT_OFF:  rdata[`RTA_WRAP_BIT:`RTA_TICK_BIT] = flag_reg;
        `RTA_TICK_RLD_OFF:  rdata[`RTA_TICK_RLD_MSB:0] = tick_reload_value_reg;
        `RTA_TICK_CNT_OFF:  rdata[`RTA_TICK_RLD_MSB:0] = tick_divider_count_reg;
        `RTA_ALARM_RLD_OFF: rdata = alarm_reload_value_reg;
        `RTA_TIME_CNT_OFF:  rdata = time_counter_reg;
        default:            rdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok & ~hwrite) begin
      hrdata <= rdata;
    end
  end

endmodule
`default_nettype wire

// *** test/rta_tick_alarm_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// bus side checks
// ----
module rta_tick_alarm_chk (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // interrupt lines
  input wire logic        tick_irq,
  input wire logic        match_irq,
  input wire logic        wrap_irq
);
  logic       ph_v;
  logic       ph_w;
  logic [5:0] ph_a;
  logic [5:0] cfg_q;
  wire logic  rd_v;
  assign rd_v = ph_v && !ph_w;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_v  <= 1'b0;
      ph_w  <= 1'b0;
      ph_a  <= 6'h0;
      cfg_q <= 6'h0;
    end else begin
      ph_v <= hsel && htrans[1] && hready && haddr[31:6] == 26'h0;
      ph_w <= hwrite;
      ph_a <= haddr[5:0];
      if (ph_v && ph_w && ph_a == 6'h00) cfg_q[0] <= hwdata[0];
      if (ph_v && ph_w && ph_a == 6'h04) cfg_q[2:1] <= hwdata[1:0];
      if (ph_v && ph_w && ph_a == 6'h08) cfg_q[5:3] <= hwdata[2:0];
    end
  end
  a_run_readback: assert property (rd_v && ph_a == 6'h00 |-> hrdata == {31'h0, cfg_q[0]})
    else $error("control readback wrong");
  a_sel_readback: assert property (rd_v && ph_a == 6'h04 |-> hrdata == {30'h0, cfg_q[2:1]})
    else $error("select readback wrong");
  a_enable_readback: assert property (rd_v && ph_a == 6'h08 |-> hrdata == {29'h0, cfg_q[5:3]})
    else $error("enable readback wrong");
  a_clear_reads_zero: assert property (rd_v && ph_a == 6'h10 |-> hrdata == 32'h0)
    else $error("clear register not zero");
  a_reload_nonzero: assert property (rd_v && ph_a == 6'h14 |-> hrdata[31:20] == 12'h0 && hrdata != 32'h0)
    else $error("tick reload out of range");
  a_alarm_nonzero: assert property (rd_v && ph_a == 6'h1c |-> hrdata != 32'h0)
    else $error("alarm reload zero");
  a_status_narrow: assert property (rd_v && ph_a == 6'h0c |-> hrdata[31:3] == 29'h0)
    else $error("status upper bits set");
  a_irq_gated: assert property (({wrap_irq, match_irq, tick_irq} & ~$past(cfg_q[5:3])) == 3'h0)
    else $error("interrupt line without enable");
endmodule
bind rta_tick_alarm rta_tick_alarm_chk i_rta_tick_alarm_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .tick_irq(tick_irq), .match_irq(match_irq), .wrap_irq(wrap_irq));
`default_nettype wire

// *** test/rta_tick_alarm_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// bench top
// ----
module rta_tick_alarm_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        wake = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  osc = 3'h0;
  logic [7:0]  cyc = 8'h0;
  logic [31:0] v;
  logic [31:0] t;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire  [2:0]  irq;
  int          err_count = 0;
  int          cmp_count = 0;
  rta_tick_alarm i_rta_tick_alarm (
    .hclk(hclk), .hresetn(hresetn), .deep_sleep_wake_reset(wake), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .internal_low_speed_osc(osc[0]),
    .external_low_speed_crystal(osc[1]), .external_high_speed_crystal(osc[2]),
    .tick_irq(irq[0]), .match_irq(irq[1]), .wrap_irq(irq[2]));
  initial forever #50 hclk = ~hclk;
  // slow square waves for the three sources
  always @(posedge hclk) begin
    cyc <= cyc + 8'h1;
    osc <= {cyc[1], cyc[4], cyc[3]};
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk($sformatf("reg %h", a), v, e);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      xfer(a, 1'b0, 32'h0);
      n++;
    end while ((v & m) !== e && n < 2000);
    chk($sformatf("poll %h", a), v & m, e);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic t_reset;
    rc(8'h00, 32'h0);
    rc(8'h0c, 32'h0);
    rc(8'h14, 32'h8000);
    rc(8'h1c, 32'hffffffff);
    rc(8'h20, 32'h0);
    wr(8'h08, 32'hffffffff);
    rc(8'h08, 32'h7);
    wr(8'h40, 32'h1);
    rc(8'h40, 32'h0);
    wr(8'h14, 32'h0);
    rc(8'h14, 32'h8000);
    wr(8'h14, 32'hfff00002);
    rc(8'h14, 32'h2);
    wr(8'h1c, 32'h0);
    rc(8'h1c, 32'hffffffff);
    $display("test reset done");
  endtask
  task automatic t_count;
    wr(8'h1c, 32'h2);
    wr(8'h00, 32'h1);
    poll(8'h0c, 32'h1, 32'h1);
    rc(8'h20, 32'h0);
    rc(8'h18, 32'h0);
    poll(8'h0c, 32'h2, 32'h2);
    rc(8'h20, 32'h1);
    @(posedge hclk);
    #1;
    chk("irq", {29'h0, irq}, 32'h3);
    wr(8'h08, 32'h1);
    @(posedge hclk);
    #1;
    chk("irq", {29'h0, irq}, 32'h1);
    $display("test count done");
  endtask
  task automatic t_clear;
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h0);
    rc(8'h0c, 32'h3);
    wr(8'h10, 32'h2);
    rc(8'h0c, 32'h1);
    rc(8'h10, 32'h0);
    xfer(8'h20, 1'b0, 32'h0);
    t = v;
    repeat (100) @(posedge hclk);
    rc(8'h20, t);
    wr(8'h04, 32'h1);
    rc(8'h20, 32'h0);
    wr(8'h00, 32'h1);
    poll(8'h20, 32'hffffffff, 32'h1);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h1);
    rc(8'h20, 32'h0);
    poll(8'h20, 32'hffffffff, 32'h1);
    wr(8'h1c, 32'h7);
    rc(8'h20, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h7);
    rc(8'h0c, 32'h0);
    $display("test clear done");
  endtask
  task automatic t_sel;
    logic [1:0] code [3] = '{2'h0, 2'h1, 2'h3};
    foreach (code[i]) begin
      wr(8'h00, 32'h0);
      wr(8'h04, {30'h0, code[i]});
      wr(8'h00, 32'h1);
      poll(8'h20, 32'hffffffff, 32'h1);
    end
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h1);
    repeat (600) @(posedge hclk);
    rc(8'h18, 32'h0);
    wr(8'h14, 32'h5);
    @(posedge hclk);
    wake <= 1'b1;
    @(posedge hclk);
    wake <= 1'b0;
    rc(8'h14, 32'h8000);
    rc(8'h1c, 32'hffffffff);
    rc(8'h04, 32'h2);
    $display("test select done");
  endtask
  initial begin
    #3000000;
    err_count++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_count();
    t_clear();
    t_sel();
    close_out();
  end
endmodule
`default_nettype wire
